// [dv/cdt_decode_properties.sv]
// Port checker for the data transfer decoder.
// Assumes it is bound to cdt_decode and sees only its ports.
`timescale 1ns/1ps
module cdt_decode_properties
    import cdt_pkg::*;
(
    // Clock, reset and inputs
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire cdt_insn_t insn_i,
    input wire cdt_wb_t wb_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    // Outputs
    input wire logic [15:0] rdata_o,
    input wire cdt_dec_t dec_o
);
    // ****
    // Decode enable copy
    // ****
    logic en_reg;
    wire cdt_head_t h = insn_i.head;
    wire tk = insn_i.valid && ce_i && en_reg;
    wire mv = tk && h.index == IDX_MOVE;
    wire stk = mv && h.word && h.rs == GPR_SEVEN;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            en_reg <= CTRL_RESET;
        end else if (ce_i && wr_i && addr_i == REG_CTRL) begin
            en_reg <= wdata_i[0];
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ****
    // Properties
    // ****
    AST_LATENCY: assert property (tk |=> dec_o.valid)
        else $error("decode result missing");
    AST_BAD_INDEX: assert property (tk && h.index >= INSN_COUNT |=> dec_o.valid && !dec_o.legal)
        else $error("index out of range accepted");
    AST_SHORT_WORD: assert property (mv && h.word && h.mode == MODE_SHORT_ABS |=> !dec_o.legal)
        else $error("word short absolute accepted");
    AST_BYTE_STACK: assert property (mv && !h.word && h.rs == GPR_SEVEN &&
        h.mode inside {MODE_PREDEC, MODE_POSTINC} |=> !dec_o.legal)
        else $error("byte stack move accepted");
    AST_SHORT_PAGE: assert property (mv && !h.word && h.mode == MODE_SHORT_ABS |=>
        dec_o.ea[15:8] == SHORT_ABS_PAGE)
        else $error("short absolute page wrong");
    AST_PUSH: assert property (stk && h.store && h.mode == MODE_PREDEC |=>
        dec_o.push && dec_o.mem_wr && dec_o.word)
        else $error("push not decoded");
    AST_POP: assert property (stk && !h.store && h.mode == MODE_POSTINC |=>
        dec_o.pop && dec_o.word && dec_o.load_idx == $past(h.rd))
        else $error("pop not decoded");
    AST_WORD_EVEN: assert property (dec_o.valid && dec_o.word && (dec_o.mem_rd || dec_o.mem_wr) |-> !dec_o.ea[0])
        else $error("odd word address");
    AST_TAKEN: assert property (dec_o.taken |-> dec_o.group == GRP_BRANCH && $past(h.index) == IDX_BCOND)
        else $error("taken without branch");
    cover property (dec_o.push);
    cover property (dec_o.pop);
    cover property (dec_o.taken);
endmodule

bind cdt_decode cdt_decode_properties cdt_decode_properties_i (
    .mclk_i, .rst_n_i, .ce_i, .insn_i, .wb_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .dec_o
);

// [dv/testbench.sv]
// Self-checking bench for the data transfer decoder.
// Assumes cdt_decode with its port checker bound to it.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench
    import cdt_pkg::*;
;
    logic mclk_i = '0;
    logic rst_n_i = '0;
    logic ce_i = '1;
    cdt_insn_t insn_i = '0;
    cdt_wb_t wb_i = '0;
    logic [3:0] addr_i = '0;
    logic [15:0] wdata_i = '0;
    logic wr_i = '0;
    logic rd_i = '0;
    logic [15:0] rdata_o;
    cdt_dec_t dec_o;
    cdt_dec_t d;
    int n_errors = 0;
    int cmp_count = 0;
    logic [2:0] cc [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
    logic tkn [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    always #2 mclk_i = ~mclk_i;
    cdt_decode cdt_decode_i (
        .mclk_i, .rst_n_i, .ce_i, .insn_i, .wb_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .dec_o
    );
    // ****
    // Access tasks
    // ****
    task automatic w(input logic [3:0] a, input logic [15:0] x);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= x;
        wr_i <= '1;
        @(posedge mclk_i);
        wr_i <= '0;
    endtask
    task automatic r(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= '1;
        @(posedge mclk_i);
        rd_i <= '0;
        #1;
        `CHK("rdata", e, rdata_o)
    endtask
    task automatic go(input logic [5:0] ix, input logic st, input logic wd, input cdt_mode_t m,
                      input logic [2:0] rd, input logic [2:0] rs, input logic [15:0] x);
        @(posedge mclk_i);
        insn_i <= '{1'b1, '{ix, st, wd, m, rd, rs}, x};
        @(posedge mclk_i);
        insn_i.valid <= '0;
        #1;
        d = dec_o;
    endtask
    function automatic cdt_group_t grp(input int i);
        return i < 15 ? GRP_ARITH : i < 19 ? GRP_LOGIC : i < 27 ? GRP_SHIFT : i < 41 ? GRP_BIT :
            i < 46 ? GRP_BRANCH : i < 54 ? GRP_SYSCTL : GRP_BLOCK;
    endfunction
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_errors++;
        report_and_stop();
    end
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= '1;
        r(REG_CTRL, 16'h0001);
        r(REG_COND_CODE, 16'h0000);
        w(4'h5, 16'hFFFF);
        r(4'h5, 16'h0000);
        w(4'hF, 16'h0100);
        w(4'h9, 16'h1234);
        go(IDX_MOVE, '1, '1, MODE_PREDEC, 3'h1, GPR_SEVEN, '0);
        `CHK("push", 3'h7, {d.push, d.mem_wr, d.word})
        `CHK("st_data", 16'h1234, d.st_data)
        `CHK("group", GRP_TRANSFER, d.group)
        `CHK("ea", 16'h00FE, d.ea)
        r(REG_STATUS, 16'h00C5);
        r(4'hF, 16'h00FE);
        go(IDX_MOVE, '0, '1, MODE_POSTINC, 3'h2, GPR_SEVEN, '0);
        `CHK("pop", 6'h3A, {d.pop, d.mem_rd, d.load_wr, d.load_idx})
        `CHK("ea", 16'h00FE, d.ea)
        r(4'hF, 16'h0100);
        @(posedge mclk_i) wb_i <= '{1'b1, 3'h2, 16'hBEEF};
        @(posedge mclk_i) wb_i.valid <= '0;
        r(4'hA, 16'hBEEF);
        w(4'hB, 16'h0011);
        go(IDX_MOVE, '0, '0, MODE_POSTINC, 3'h0, 3'h3, '0);
        `CHK("ea", 16'h0011, d.ea)
        r(4'hB, 16'h0012);
        go(IDX_MOVE, '1, '0, MODE_PREDEC, 3'h0, 3'h3, '0);
        `CHK("ea", 16'h0011, d.ea)
        r(4'hB, 16'h0011);
        go(IDX_MOVE, '0, '1, MODE_DISP, 3'h0, 3'h3, 16'h0010);
        `CHK("ea", 16'h0020, d.ea)
        go(IDX_MOVE, '0, '1, MODE_LONG_ABS, 3'h0, 3'h0, 16'h1235);
        `CHK("ea", 16'h1234, d.ea)
        go(IDX_MOVE, '0, '0, MODE_IND, 3'h0, 3'h3, '0);
        `CHK("ea", 16'h0011, d.ea)
        go(IDX_MOVE, '1, '0, MODE_SHORT_ABS, 3'h0, 3'h0, 16'h0034);
        `CHK("ea", 16'hFF34, d.ea)
        `CHK("legal", 1'b1, d.legal)
        go(IDX_MOVE, '0, '1, MODE_SHORT_ABS, 3'h0, 3'h0, 16'h0034);
        `CHK("legal", 1'b0, d.legal)
        go(IDX_MOVE, '1, '0, MODE_PREDEC, 3'h1, GPR_SEVEN, '0);
        `CHK("legal", 1'b0, d.legal)
        go(INSN_COUNT, '0, '0, MODE_REG, 3'h0, 3'h0, '0);
        `CHK("legal", 1'b0, d.legal)
        @(posedge mclk_i);
        #1;
        `CHK("valid idle", 1'b0, dec_o.valid)
        r(4'hF, 16'h0100);
        r(REG_ILLEGAL, 16'h0003);
        @(posedge mclk_i);
        #1;
        `CHK("rdata idle", 16'h0000, rdata_o)
        w(REG_CTRL, 16'h0000);
        go(IDX_MOVE, '0, '1, MODE_WIDE_IMM, 3'h4, 3'h0, 16'h7777);
        `CHK("valid", 1'b0, d.valid)
        w(REG_CTRL, 16'h0001);
        w(REG_COND_CODE, 16'h0001);
        go(IDX_MOVE, '0, '1, MODE_WIDE_IMM, 3'h4, 3'h0, 16'h8000);
        r(4'hC, 16'h8000);
        r(REG_COND_CODE, 16'h0009);
        go(IDX_MOVE, '0, '1, MODE_REG, 3'h5, 3'h4, '0);
        r(4'hD, 16'h8000);
        go(IDX_MOVE, '0, '0, MODE_WIDE_IMM, 3'h5, 3'h0, 16'h0000);
        r(4'hD, 16'h8000);
        r(REG_COND_CODE, 16'h0005);
        @(posedge mclk_i) ce_i <= '0;
        w(4'hE, 16'h5555);
        @(posedge mclk_i) ce_i <= '1;
        r(4'hE, 16'h0000);
        go(IDX_MOVE, '1, '1, MODE_WIDE_IMM, 3'h4, 3'h0, 16'h1111);
        `CHK("legal", 1'b0, d.legal)
        go(IDX_MOVE, '0, '1, MODE_PREDEC, 3'h4, 3'h3, '0);
        `CHK("legal", 1'b0, d.legal)
        go(IDX_MOVE, '1, '1, MODE_POSTINC, 3'h4, 3'h3, '0);
        `CHK("legal", 1'b0, d.legal)
        r(4'hC, 16'h8000);
        r(4'hB, 16'h0011);
        r(REG_ILLEGAL, 16'h0006);
        w(REG_ILLEGAL, 16'h0000);
        r(REG_ILLEGAL, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            go(IDX_BCOND, '0, '0, MODE_REG, 3'h0, cc[i], '0);
            `CHK("taken", {1'b0, cc[i], tkn[i]}, {d.cond, d.taken})
        end
        for (int i = 1; i < 55; i++) begin
            go(i[5:0], '0, '0, MODE_REG, 3'h0, 3'h0, '0);
            `CHK("group", {1'b1, grp(i)}, {d.legal, d.group})
        end
        report_and_stop();
    end
endmodule

// [hdl/cdt_decode.sv]
// Data transfer decoder with general registers and condition codes.
// Assumes fetch presents one predecoded head per cycle, same clock domain.
//
// Operation
// - 55 instructions sorted into eight groups
// - Push is word store predecrement on gpr_seven
// - Pop is word load postincrement on gpr_seven
// - Conditional branch carries condition code field
// - Moves between registers, memory and immediates
// - Eight addressing modes, seven of them for both byte and word
// - Short absolute mode for byte moves only
// - Pop always moves a full word
// - Push always moves a full word
// - Condition codes hold N, Z, V, C
// - Postincrement adds one or two afterwards
// - Predecrement subtracts first, keeps result
// - Short absolute forces upper byte to ones
// - Odd word address drops its lowest bit
`timescale 1ns/1ps

module cdt_decode
    import cdt_pkg::*;
(
    // Clock, reset and enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Instruction in and load write-back
    input wire cdt_insn_t insn_i,
    input wire cdt_wb_t wb_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Decode result
    output cdt_dec_t dec_o
);

    // ****************************************
    // State
    // ****************************************
    logic [15:0] gpr_reg [0:7];
    logic [3:0] cond_code_reg;
    logic ctrl_reg;
    logic [15:0] illegal_reg;
    logic [15:0] status_reg;
    logic [15:0] rdata_reg;
    cdt_dec_t dec_reg;

    // ****************************************
    // Field decode
    // ****************************************
    cdt_head_t head;
    logic [15:0] ext;
    logic fire;
    logic is_move;
    logic in_range;
    cdt_group_t group;

    assign head = insn_i.head;
    assign ext = insn_i.ext;
    assign fire = insn_i.valid && ctrl_reg;
    assign in_range = head.index < INSN_COUNT;
    assign is_move = head.index == IDX_MOVE;

    // Each group owns a contiguous run of indices.
    assign group = (head.index >= IDX_BLOCK) ? GRP_BLOCK :
        (head.index >= IDX_SYSCTL) ? GRP_SYSCTL :
        (head.index >= IDX_BRANCH) ? GRP_BRANCH :
        (head.index >= IDX_BIT) ? GRP_BIT :
        (head.index >= IDX_SHIFT) ? GRP_SHIFT :
        (head.index >= IDX_LOGIC) ? GRP_LOGIC :
        (head.index >= IDX_ARITH) ? GRP_ARITH : GRP_TRANSFER;

    // ****************************************
    // Mode decode
    // ****************************************
    logic m_reg;
    logic m_imm;
    logic m_pre;
    logic m_post;
    logic m_short;
    logic on_stack;

    assign m_reg = head.mode == MODE_REG;
    assign m_imm = head.mode == MODE_WIDE_IMM;
    assign m_pre = head.mode == MODE_PREDEC;
    assign m_post = head.mode == MODE_POSTINC;
    assign m_short = head.mode == MODE_SHORT_ABS;
    assign on_stack = head.rs == GPR_SEVEN;

    // ****************************************
    // Effective address
    // ****************************************
    logic [15:0] base;
    logic [15:0] src_val;
    logic [15:0] dat_val;
    logic [15:0] step;
    logic [15:0] dec_addr;
    logic [15:0] inc_addr;
    logic [15:0] raw_ea;
    logic [15:0] ea;

    assign base = gpr_reg[head.rs];
    assign src_val = gpr_reg[head.rs];
    assign dat_val = gpr_reg[head.rd];
    assign step = head.word ? STEP_WORD : STEP_BYTE;
    assign dec_addr = base - step;
    assign inc_addr = base + step;

    assign raw_ea = (head.mode == MODE_IND) ? base :
        (head.mode == MODE_DISP) ? base + ext :
        (head.mode == MODE_LONG_ABS) ? ext :
        m_short ? {SHORT_ABS_PAGE, ext[7:0]} :
        m_pre ? dec_addr :
        m_post ? base : 16'h0000;

    // Word accesses never straddle a word boundary.
    assign ea = head.word ? {raw_ea[15:1], 1'b0} : raw_ea;

    // ****************************************
    // Legality
    // ****************************************
    logic bad_short;
    logic bad_stack;
    logic bad_dir;
    logic legal;

    assign bad_short = m_short && head.word;
    assign bad_stack = on_stack && (m_pre || m_post) && !head.word;
    assign bad_dir = (m_pre && !head.store) || (m_post && head.store) ||
        (m_imm && head.store);
    assign legal = in_range && !(is_move && (bad_short || bad_stack || bad_dir));

    // ****************************************
    // Move actions
    // ****************************************
    logic mv_ok;
    logic mem_rd;
    logic mem_wr;
    logic push;
    logic pop;
    logic areg_wr;
    logic dreg_wr;
    logic [15:0] areg_val;
    logic [15:0] dreg_val;
    logic [15:0] flag_src;
    logic flag_upd;

    assign mv_ok = fire && legal && is_move;
    assign mem_rd = mv_ok && !head.store && !m_reg && !m_imm;
    assign mem_wr = mv_ok && head.store && !m_reg;
    assign push = mem_wr && m_pre && on_stack && head.word;
    assign pop = mem_rd && m_post && on_stack && head.word;
    assign areg_wr = mv_ok && (m_pre || m_post);
    assign areg_val = m_pre ? dec_addr : inc_addr;
    assign dreg_wr = mv_ok && (m_reg || m_imm);

    // A byte move into a register keeps the upper byte of the target.
    assign dreg_val = head.word ? (m_imm ? ext : src_val) :
        {dat_val[15:8], (m_imm ? ext[7:0] : src_val[7:0])};
    assign flag_src = (m_reg || m_imm) ? (m_imm ? ext : src_val) : dat_val;
    assign flag_upd = mv_ok && (m_reg || m_imm || head.store);

    // ****************************************
    // Condition codes
    // ****************************************
    logic f_n;
    logic f_z;
    logic f_v;
    logic f_c;
    logic [3:0] cond;
    logic taken;
    logic [3:0] cond_code_next;
    logic new_n;
    logic new_z;

    assign f_n = cond_code_reg[FLAG_N];
    assign f_z = cond_code_reg[FLAG_Z];
    assign f_v = cond_code_reg[FLAG_V];
    assign f_c = cond_code_reg[FLAG_C];
    assign cond = {head.rd[0], head.rs};

    assign taken = (cond == 4'h0) ? 1'b1 :
        (cond == 4'h1) ? 1'b0 :
        (cond == 4'h2) ? !(f_c || f_z) :
        (cond == 4'h3) ? (f_c || f_z) :
        (cond == 4'h4) ? !f_c :
        (cond == 4'h5) ? f_c :
        (cond == 4'h6) ? !f_z :
        (cond == 4'h7) ? f_z :
        (cond == 4'h8) ? !f_v :
        (cond == 4'h9) ? f_v :
        (cond == 4'hA) ? !f_n :
        (cond == 4'hB) ? f_n :
        (cond == 4'hC) ? (f_n == f_v) :
        (cond == 4'hD) ? (f_n != f_v) :
        (cond == 4'hE) ? (!f_z && (f_n == f_v)) : (f_z || (f_n != f_v));

    // Moves other than memory loads set N and Z from the moved value, clear V and keep C.
    assign new_n = head.word ? flag_src[15] : flag_src[7];
    assign new_z = head.word ? (flag_src == 16'h0000) : (flag_src[7:0] == 8'h00);
    assign cond_code_next = flag_upd ? {new_n, new_z, 1'b0, f_c} :
        (wr_i && addr_i == REG_COND_CODE) ? wdata_i[3:0] : cond_code_reg;

    // ****************************************
    // Decode result
    // ****************************************
    cdt_dec_t dec_next;

    assign dec_next = '{
        valid: fire,
        legal: fire && legal,
        group: group,
        cond: cond,
        taken: fire && legal && head.index == IDX_BCOND && taken,
        word: head.word,
        mode: head.mode,
        mem_rd: mem_rd,
        mem_wr: mem_wr,
        ea: (mem_rd || mem_wr) ? ea : 16'h0000,
        st_data: mem_wr ? dat_val : 16'h0000,
        load_wr: mem_rd,
        load_idx: head.rd,
        push: push,
        pop: pop
    };

    // ****************************************
    // Register port decode
    // ****************************************
    logic hit_gpr;
    logic [15:0] rd_mux;
    logic [15:0] status_next;
    logic [15:0] illegal_next;
    logic bump_illegal;

    assign hit_gpr = addr_i[3] == REG_GPR_BASE[3];
    assign rd_mux = hit_gpr ? gpr_reg[addr_i[2:0]] :
        (addr_i == REG_CTRL) ? {15'h0000, ctrl_reg} :
        (addr_i == REG_STATUS) ? status_reg :
        (addr_i == REG_COND_CODE) ? {12'h000, cond_code_reg} :
        (addr_i == REG_ILLEGAL) ? illegal_reg : 16'h0000;

    // Status keeps the last decode: a set bit, legal, group, push, pop, word.
    assign status_next = fire ? {8'h00, 1'b1, legal, group, push, pop, head.word} :
        status_reg;
    assign bump_illegal = fire && !legal && illegal_reg != 16'hFFFF;
    // A new illegal decode is still counted when it meets a clear.
    assign illegal_next = (wr_i && addr_i == REG_ILLEGAL) ? {15'h0000, fire && !legal} :
        bump_illegal ? illegal_reg + 16'h0001 : illegal_reg;

    // ****************************************
    // General registers
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_gpr
            logic a_hit;
            logic d_hit;
            logic w_hit;
            logic b_hit;
            logic [15:0] nxt;

            assign a_hit = areg_wr && head.rs == 3'(gi);
            assign d_hit = dreg_wr && head.rd == 3'(gi);
            assign w_hit = wb_i.valid && wb_i.idx == 3'(gi);
            assign b_hit = wr_i && hit_gpr && addr_i[2:0] == 3'(gi);
            assign nxt = a_hit ? areg_val :
                d_hit ? dreg_val :
                w_hit ? wb_i.data :
                b_hit ? wdata_i : gpr_reg[gi];

            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    gpr_reg[gi] <= GPR_RESET;
                end else if (ce_i) begin
                    gpr_reg[gi] <= nxt;
                end
            end
        end
    endgenerate

    // ****************************************
    // Control, status and outputs
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= CTRL_RESET;
            cond_code_reg <= COND_CODE_RESET;
            status_reg <= 16'h0000;
            illegal_reg <= 16'h0000;
            rdata_reg <= 16'h0000;
            dec_reg <= '0;
        end else if (ce_i) begin
            if (wr_i && addr_i == REG_CTRL) begin
                ctrl_reg <= wdata_i[0];
            end
            cond_code_reg <= cond_code_next;
            status_reg <= status_next;
            illegal_reg <= illegal_next;
            rdata_reg <= rd_i ? rd_mux : 16'h0000;
            dec_reg <= dec_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign dec_o = dec_reg;

endmodule

// [hdl/cdt_pkg.sv]
// Constants, encodings and carrier types for the data transfer decoder.
// Assumes a single clock domain and a predecoded instruction head from fetch.
package cdt_pkg;

    // ****************************************
    // Instruction indices and groups
    // ****************************************
    localparam logic [5:0] INSN_COUNT = 6'h37;
    localparam logic [5:0] IDX_MOVE = 6'h00;
    localparam logic [5:0] IDX_ARITH = 6'h01;
    localparam logic [5:0] IDX_LOGIC = 6'h0F;
    localparam logic [5:0] IDX_SHIFT = 6'h13;
    localparam logic [5:0] IDX_BIT = 6'h1B;
    localparam logic [5:0] IDX_BRANCH = 6'h29;
    localparam logic [5:0] IDX_SYSCTL = 6'h2E;
    localparam logic [5:0] IDX_BLOCK = 6'h36;
    localparam logic [5:0] IDX_BCOND = 6'h29;

    typedef enum logic [2:0] {
        GRP_TRANSFER = 3'b000,
        GRP_ARITH = 3'b001,
        GRP_LOGIC = 3'b010,
        GRP_SHIFT = 3'b011,
        GRP_BIT = 3'b100,
        GRP_BRANCH = 3'b101,
        GRP_SYSCTL = 3'b110,
        GRP_BLOCK = 3'b111
    } cdt_group_t;

    typedef enum logic [2:0] {
        MODE_REG = 3'b000,
        MODE_IND = 3'b001,
        MODE_DISP = 3'b010,
        MODE_LONG_ABS = 3'b011,
        MODE_SHORT_ABS = 3'b100,
        MODE_WIDE_IMM = 3'b101,
        MODE_PREDEC = 3'b110,
        MODE_POSTINC = 3'b111
    } cdt_mode_t;

    // ****************************************
    // Addressing and flag constants
    // ****************************************
    localparam logic [2:0] GPR_SEVEN = 3'h7;
    localparam logic [7:0] SHORT_ABS_PAGE = 8'hFF;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    localparam logic [3:0] COND_CODE_RESET = 4'h0;
    localparam logic [15:0] GPR_RESET = 16'h0000;

    // ****************************************
    // Register port map
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_COND_CODE = 4'h2;
    localparam logic [3:0] REG_ILLEGAL = 4'h3;
    localparam logic [3:0] REG_GPR_BASE = 4'h8;
    localparam logic CTRL_RESET = 1'b1;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic [5:0] index;
        logic store;
        logic word;
        cdt_mode_t mode;
        logic [2:0] rd;
        logic [2:0] rs;
    } cdt_head_t;

    typedef struct packed {
        logic valid;
        cdt_head_t head;
        logic [15:0] ext;
    } cdt_insn_t;

    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic [15:0] data;
    } cdt_wb_t;

    typedef struct packed {
        logic valid;
        logic legal;
        cdt_group_t group;
        logic [3:0] cond;
        logic taken;
        logic word;
        cdt_mode_t mode;
        logic mem_rd;
        logic mem_wr;
        logic [15:0] ea;
        logic [15:0] st_data;
        logic load_wr;
        logic [2:0] load_idx;
        logic push;
        logic pop;
    } cdt_dec_t;

endpackage
